//--- logic/timer_channel.sv
// one capture/compare/pwm channel with its flag and value buffering
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_channel (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // counter view
   input  wire logic        tick,
   input  wire logic [15:0] cnt,
   input  wire logic [15:0] next_cnt,
   input  wire logic [15:0] modulo,
   input  wire logic        center,
   input  wire logic        clk_off,
   input  wire logic        halt,
   input  wire logic        pwm_load,
   input  wire logic        period_start,
   // capture pin
   input  wire logic        pin,
   // register access
   input  wire logic        wr_sc,
   input  wire logic        wr_vh,
   input  wire logic        wr_vl,
   input  wire logic        rd_sc,
   input  wire logic        rd_vh,
   input  wire logic        rd_vl,
   input  wire logic [7:0]  wdata,
   // results
   output logic      [7:0]  sc_rd,
   output logic      [7:0]  hi_rd,
   output logic      [7:0]  lo_rd,
   output logic             irq_req,
   output logic             pwm_out
);

   localparam timer_pkg::chan_state_s RST = '{sc: `CSC_RST, default: '0};

   timer_pkg::chan_state_s s;
   timer_pkg::chan_state_s n;
   logic                   capture;
   logic                   compare;
   logic                   rise;
   logic                   fall;
   logic                   ev;
   logic                   act;
   logic [1:0]             els;

   assign sc_rd   = s.sc;
   assign hi_rd   = s.val[15:8];
   assign lo_rd   = (s.lat && !halt) ? s.vlat : s.val[7:0];
   assign irq_req = s.sc[`FLAG_BIT] & s.sc[`IE_BIT];

   // ==========================================================================
   // next state
   always_comb begin
      n       = s;
      els     = s.sc[`ELS_HI:`ELS_LO];
      capture = !center && (s.sc[`MS_HI:`MS_LO] == 2'h0);
      compare = !center && (s.sc[`MS_HI:`MS_LO] == 2'h1);
      // pin passes two flops; the third only feeds the edge detector
      n.pin_s1 = pin;
      n.pin_s2 = s.pin_s1;
      n.pin_s3 = s.pin_s2;
      rise     = s.pin_s2 & ~s.pin_s3;
      fall     = ~s.pin_s2 & s.pin_s3;
      ev       = 1'b0;
      if (capture) begin
         ev = (els == 2'h1 && rise) || (els == 2'h2 && fall) || (els == 2'h3 && (rise || fall));
      end else begin
         ev = tick && (next_cnt == s.val);
      end
      if (capture && ev) begin
         n.val = cnt;
      end
      if (rd_sc && s.sc[`FLAG_BIT]) begin
         n.arm = 1'b1;
      end
      if (rd_vh && !halt) begin
         n.vlat = s.val[7:0];
         n.lat  = 1'b1;
      end
      if (rd_vl && !halt) begin
         n.lat = 1'b0;
      end
      if (wr_sc) begin
         n.sc[6:0] = wdata[6:0];
         n.wh      = 1'b0;
         n.wl      = 1'b0;
         n.pend    = 1'b0;
         if (halt) begin
            n.lat = 1'b0;
         end
         if (!wdata[`FLAG_BIT] && s.arm) begin
            n.sc[`FLAG_BIT] = 1'b0;
            n.arm           = 1'b0;
         end
      end
      if (!capture) begin
         if (wr_vh) begin
            n.vbuf[15:8] = wdata;
            n.wh         = 1'b1;
         end
         if (wr_vl) begin
            n.vbuf[7:0] = wdata;
            n.wl        = 1'b1;
         end
      end
      if (s.pend && ((compare && tick) || (!capture && !compare && pwm_load))) begin
         n.val  = s.vbuf;
         n.pend = 1'b0;
      end
      if (n.wh && n.wl) begin
         n.wh = 1'b0;
         n.wl = 1'b0;
         if (clk_off) begin
            n.val  = n.vbuf;
            n.pend = 1'b0;
         end else begin
            n.pend = 1'b1;
         end
      end
      // center duty moves only at a period boundary or while the clock is off, so old and new never mix
      if (period_start || clk_off) begin
         n.duty = n.val;
      end
      if (ev) begin
         n.sc[`FLAG_BIT] = 1'b1;
         n.arm           = 1'b0;
      end
      if (center) begin
         act = (s.duty != 16'h0000) && !s.duty[15]
               && ((s.duty >= modulo) || (cnt < s.duty));
      end else begin
         act = cnt < s.val;
      end
      n.out = (!capture && !compare && els != 2'h0) ? (act ^ els[0]) : 1'b0;
   end

   // ==========================================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   assign pwm_out = s.out;

endmodule

//--- logic/timer_pkg.sv
// types shared by the timer/pwm block
package timer_pkg;

   // ==========================================================================
   // one counter step
   typedef struct packed {
      logic        up;
      logic [15:0] cnt;
      logic        ovf;
   } step_s;

   // ==========================================================================
   // whole state of one channel
   typedef struct packed {
      logic [7:0]  sc;
      logic        arm;
      logic [15:0] val;
      logic [15:0] duty;
      logic [15:0] vbuf;
      logic        wh;
      logic        wl;
      logic        pend;
      logic [7:0]  vlat;
      logic        lat;
      logic        pin_s1;
      logic        pin_s2;
      logic        pin_s3;
      logic        out;
   } chan_state_s;

   // ==========================================================================
   // whole state of the module core and bus slave
   typedef struct packed {
      logic [7:0]  sc;
      logic        ovf_arm;
      logic [15:0] cnt;
      logic        up;
      logic [6:0]  ps;
      logic [15:0] modulo;
      logic [15:0] mod_buf;
      logic        mod_wh;
      logic        mod_wl;
      logic [7:0]  cnt_buf;
      logic        cnt_lat;
      logic        halt_s1;
      logic        halt_s2;
      logic        ext_s1;
      logic        ext_s2;
      logic        ext_s3;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } top_state_s;

endpackage

//--- logic/timer_pwm.sv
// timer/pwm module core: counter, flags, byte coherency and apb slave
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_pwm (
   // clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // pins
   input  wire logic                 debug_halt,
   input  wire logic                 ext_clk_pin,
   input  wire logic [`NUM_CH-1:0]   capture_pin,
   output logic      [`NUM_CH-1:0]   pwm_out,
   // interrupt
   output logic                      irq
);

   localparam timer_pkg::top_state_s RST = '{sc: `SC_RST, modulo: `MOD_RST, up: 1'b1,
                                           default: '0};

   // ==========================================================================
   // helpers
   function automatic logic [6:0] presc_mask(input logic [2:0] sel);
      logic [7:0] m;
      m = (8'h01 << sel) - 8'h01;
      return m[6:0];
   endfunction

   function automatic timer_pkg::step_s count_step(input logic [15:0] c,
                                                   input logic [15:0] top,
                                                   input logic        ctr,
                                                   input logic        up);
      timer_pkg::step_s r;
      r.up  = up;
      r.cnt = c + 16'h0001;
      r.ovf = 1'b0;
      if (!ctr) begin
         r.up = 1'b1;
         if (c == top) begin
            r.cnt = 16'h0000;
            r.ovf = 1'b1;
         end
      end else if (up) begin
         if (c >= top) begin
            r.up  = 1'b0;
            r.cnt = c - 16'h0001;
            r.ovf = 1'b1;
         end
      end else begin
         if (c == 16'h0000) begin
            r.up = 1'b1;
         end else begin
            r.cnt = c - 16'h0001;
         end
      end
      return r;
   endfunction

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
      return a == b;
   endfunction

   // ==========================================================================
   // state and nets
   timer_pkg::top_state_s s;
   timer_pkg::top_state_s n;
   timer_pkg::step_s      stp;
   logic                  halt;
   logic                  clk_on;
   logic                  inc_src;
   logic                  pre_en;
   logic                  tick;
   logic [15:0]           top;
   logic [15:0]           next_cnt;
   logic                  pwm_load;
   logic                  period_start;
   logic                  setup;
   logic                  done;
   logic                  rd_setup;
   logic                  wr_done;
   logic [7:0]            wb;
   logic [7:0]            rd_byte;
   logic                  hit;

   logic [`NUM_CH-1:0]    ch_wr_sc;
   logic [`NUM_CH-1:0]    ch_wr_vh;
   logic [`NUM_CH-1:0]    ch_wr_vl;
   logic [`NUM_CH-1:0]    ch_rd_sc;
   logic [`NUM_CH-1:0]    ch_rd_vh;
   logic [`NUM_CH-1:0]    ch_rd_vl;
   logic [7:0]            ch_sc_rd [`NUM_CH];
   logic [7:0]            ch_hi_rd [`NUM_CH];
   logic [7:0]            ch_lo_rd [`NUM_CH];
   logic [`NUM_CH-1:0]    ch_irq;
   logic [`NUM_CH-1:0]    ch_out;

   // ==========================================================================
   // counter clocking
   always_comb begin
      halt    = s.halt_s2;
      clk_on  = s.sc[`CLKS_HI:`CLKS_LO] != `CLK_OFF;
      inc_src = (s.sc[`CLKS_HI:`CLKS_LO] == `CLK_EXT) ? (s.ext_s2 & ~s.ext_s3) : 1'b1;
      // halt freezes the count so debug reads see a stable value
      pre_en  = clk_on && inc_src && !halt;
      tick    = pre_en && ((s.ps & presc_mask(s.sc[`PS_HI:0])) == presc_mask(s.sc[`PS_HI:0]));
      top     = (s.modulo == 16'h0000) ? `FREE_TOP : s.modulo;
      stp     = count_step(s.cnt, top, s.sc[`CENTER_BIT], s.up);
      next_cnt     = stp.cnt;
      pwm_load     = tick && s.up && (s.cnt == top - 16'h0001);
      period_start = tick && (stp.cnt == 16'h0000);
   end

   // ==========================================================================
   // bus decode
   always_comb begin
      setup    = psel && !penable;
      done     = psel && penable && s.pready;
      rd_setup = setup && !pwrite;
      wr_done  = done && pwrite;
      wb       = pwdata[7:0];
      ch_wr_sc = '0;
      ch_wr_vh = '0;
      ch_wr_vl = '0;
      ch_rd_sc = '0;
      ch_rd_vh = '0;
      ch_rd_vl = '0;
      rd_byte  = 8'h00;
      hit      = 1'b1;
      if (is_addr(paddr, `SC_ADDR)) begin
         rd_byte = s.sc;
      end else if (is_addr(paddr, `CNTH_ADDR)) begin
         rd_byte = s.cnt[15:8];
      end else if (is_addr(paddr, `CNTL_ADDR)) begin
         rd_byte = (s.cnt_lat && !halt) ? s.cnt_buf : s.cnt[7:0];
      end else if (is_addr(paddr, `MODH_ADDR)) begin
         rd_byte = s.modulo[15:8];
      end else if (is_addr(paddr, `MODL_ADDR)) begin
         rd_byte = s.modulo[7:0];
      end else begin
         hit = 1'b0;
      end
      for (int i = 0; i < `NUM_CH; i++) begin
         if (is_addr(paddr, `CH_BASE + 8'(i) * `CH_STRIDE + `CH_SC_OFS)) begin
            hit         = 1'b1;
            rd_byte     = ch_sc_rd[i];
            ch_wr_sc[i] = wr_done;
            ch_rd_sc[i] = rd_setup;
         end
         if (is_addr(paddr, `CH_BASE + 8'(i) * `CH_STRIDE + `CH_VH_OFS)) begin
            hit         = 1'b1;
            rd_byte     = ch_hi_rd[i];
            ch_wr_vh[i] = wr_done;
            ch_rd_vh[i] = rd_setup;
         end
         if (is_addr(paddr, `CH_BASE + 8'(i) * `CH_STRIDE + `CH_VL_OFS)) begin
            hit         = 1'b1;
            rd_byte     = ch_lo_rd[i];
            ch_wr_vl[i] = wr_done;
            ch_rd_vl[i] = rd_setup;
         end
      end
   end

   // ==========================================================================
   // next state
   always_comb begin
      n = s;
      // both pins pass two flops; ext_s3 only feeds the edge detector
      n.halt_s1 = debug_halt;
      n.halt_s2 = s.halt_s1;
      n.ext_s1  = ext_clk_pin;
      n.ext_s2  = s.ext_s1;
      n.ext_s3  = s.ext_s2;

      // answer one cycle after setup: pready rises in the first access cycle
      n.pready  = setup;
      n.pslverr = setup && !hit;
      if (setup) begin
         n.prdata = {24'h000000, hit ? rd_byte : 8'h00};
      end

      // read side effects happen with the data capture
      if (rd_setup && is_addr(paddr, `SC_ADDR) && s.sc[`FLAG_BIT]) begin
         n.ovf_arm = 1'b1;
      end
      if (rd_setup && is_addr(paddr, `CNTH_ADDR) && !halt) begin
         n.cnt_buf = s.cnt[7:0];
         n.cnt_lat = 1'b1;
      end
      if (rd_setup && is_addr(paddr, `CNTL_ADDR) && !halt) begin
         n.cnt_lat = 1'b0;
      end

      // counter runs first; a counter write below overrides it
      if (pre_en) begin
         n.ps = s.ps + 7'h01;
      end
      if (tick) begin
         n.cnt = stp.cnt;
         n.up  = stp.up;
      end

      if (wr_done && is_addr(paddr, `SC_ADDR)) begin
         n.sc[6:0] = wb[6:0];
         // a control write drops any half written modulo pair
         n.mod_wh  = 1'b0;
         n.mod_wl  = 1'b0;
         if (halt) begin
            n.cnt_lat = 1'b0;
         end
         if (!wb[`FLAG_BIT] && s.ovf_arm) begin
            n.sc[`FLAG_BIT] = 1'b0;
            n.ovf_arm       = 1'b0;
         end
      end
      if (wr_done && (is_addr(paddr, `CNTH_ADDR) || is_addr(paddr, `CNTL_ADDR))) begin
         n.cnt     = 16'h0000;
         n.ps      = 7'h00;
         n.up      = 1'b1;
         n.cnt_lat = 1'b0;
      end
      if (wr_done && is_addr(paddr, `MODH_ADDR)) begin
         n.mod_buf[15:8] = wb;
         n.mod_wh        = 1'b1;
      end
      if (wr_done && is_addr(paddr, `MODL_ADDR)) begin
         n.mod_buf[7:0] = wb;
         n.mod_wl       = 1'b1;
      end
      if (n.mod_wh && n.mod_wl) begin
         n.modulo = n.mod_buf;
         n.mod_wh = 1'b0;
         n.mod_wl = 1'b0;
      end

      // set after clear so an event in the clearing cycle survives
      if (tick && stp.ovf) begin
         n.sc[`FLAG_BIT] = 1'b1;
         n.ovf_arm       = 1'b0;
      end

      n.irq = (s.sc[`FLAG_BIT] & s.sc[`IE_BIT]) | (|ch_irq);
   end

   // ==========================================================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= RST;
      end else begin
         s <= n;
      end
   end

   // ==========================================================================
   // channels
   for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
      timer_channel u_ch (
         .pclk         (pclk),
         .presetn      (presetn),
         .tick         (tick),
         .cnt          (s.cnt),
         .next_cnt     (next_cnt),
         .modulo       (s.modulo),
         .center       (s.sc[`CENTER_BIT]),
         .clk_off      (!clk_on),
         .halt         (halt),
         .pwm_load     (pwm_load),
         .period_start (period_start),
         .pin          (capture_pin[i]),
         .wr_sc        (ch_wr_sc[i]),
         .wr_vh        (ch_wr_vh[i]),
         .wr_vl        (ch_wr_vl[i]),
         .rd_sc        (ch_rd_sc[i]),
         .rd_vh        (ch_rd_vh[i]),
         .rd_vl        (ch_rd_vl[i]),
         .wdata        (wb),
         .sc_rd        (ch_sc_rd[i]),
         .hi_rd        (ch_hi_rd[i]),
         .lo_rd        (ch_lo_rd[i]),
         .irq_req      (ch_irq[i]),
         .pwm_out      (ch_out[i])
      );
   end

   // ==========================================================================
   // outputs, all from flops
   assign prdata  = s.prdata;
   assign pready  = s.pready;
   assign pslverr = s.pslverr;
   assign irq     = s.irq;
   assign pwm_out = ch_out;

endmodule

//--- logic/timer_regs.svh
// register map, field positions and reset values of the timer/pwm block
// ==========================================================================
// Summary of operation
// - each source (overflow, capture, compare) sets its own flag on its event
// - request stays high as a level while flag and its enable are both one
// - flag clears only by reading it as one, then writing zero
// - an event between that read and the zero write restarts the clear; flag stays set
// - up mode sets overflow flag on roll from modulo (or FFFF) to 0000
// - center mode sets overflow flag at modulo where counting turns downward
// - capture edge select picks none, rising, falling or both; edge sets flag
// - compare mode sets flag whenever counter equals the 16-bit channel value
// - edge pwm sets flag on counter match, the end of the active duty
// - center pwm sets flag at both matches, start and end of active duty
// - a write to either counter byte zeroes counter and prescaler
// - in debug halt counter reads return the frozen live count
// - in debug halt a control or counter write drops the counter read latch
// - in debug halt value reads give contents; channel control write drops latch
// - channel value writes are ignored while the channel is in capture mode
// - compare mode with clock on loads buffered value at next counter step
// - pwm modes with clock on load at step modulo-1 to modulo (FFFE to FFFF)
// - center mode value equal modulo gives full duty, modulo-1 nearly full
// - center mode change from zero takes effect at next period start
// - center mode change to zero finishes current period with old duty
// - control write in debug halt cancels modulo byte write coherency
// - with clock off, buffered value loads as soon as second byte lands
// - interrupt request output is active high
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// ==========================================================================
// byte addresses on the bus
`define SC_ADDR      8'h00
`define CNTH_ADDR    8'h04
`define CNTL_ADDR    8'h08
`define MODH_ADDR    8'h0C
`define MODL_ADDR    8'h10
`define CH_BASE      8'h14
`define CH_STRIDE    8'h0C
`define CH_SC_OFS    8'h00
`define CH_VH_OFS    8'h04
`define CH_VL_OFS    8'h08
`define NUM_CH       2

// ==========================================================================
// field positions
`define FLAG_BIT     7
`define IE_BIT       6
`define CENTER_BIT   5
`define CLKS_HI      4
`define CLKS_LO      3
`define PS_HI        2
`define MS_HI        5
`define MS_LO        4
`define ELS_HI       3
`define ELS_LO       2

// ==========================================================================
// reset values and codes
`define SC_RST       8'h00
`define CSC_RST      8'h00
`define MOD_RST      16'h0000
`define CLK_OFF      2'h0
`define CLK_EXT      2'h3
`define FREE_TOP     16'hFFFF

`endif

//--- testbench/timer_pwm_event_flags_and_buffering_tb.sv
// self-checking bench of the timer/pwm flags, byte access and bus slave
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_pwm_event_flags_and_buffering_tb;
   typedef struct packed {
      logic       err;
      logic       rd;
      logic [7:0] exp;
      logic [7:0] mask;
   } note_s;
   localparam logic [7:0] C1 = `CH_BASE + `CH_STRIDE;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        debug_halt;
   logic        ext_clk_pin;
   logic [1:0]  capture_pin;
   logic [1:0]  pwm_out;
   logic        irq;
   logic [7:0]  chs;
   note_s       note_q[$];
   note_s       n;
   int          miscompares;
   int          samples_checked;
   integer      seed;
   timer_pwm u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .debug_halt(debug_halt), .ext_clk_pin(ext_clk_pin),
      .capture_pin(capture_pin), .pwm_out(pwm_out), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // =====
   // compare, bus and closing tasks
   task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, e, s);
      end
   endtask
   // request stays up after completion so a following setup needs no second assignment
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] e = 8'h00, input logic [7:0] m = 8'hFF);
      note_q.push_back('{(a > 8'h28) || (a[1:0] != 2'h0), !w, e, m});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'($random(seed)), d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
   endtask
   task automatic rel(input int c);
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (c) @(posedge pclk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         n = note_q.pop_front();
         cmp("pslverr", {7'h0, n.err}, {7'h0, pslverr});
         if (n.rd) cmp("prdata", n.exp & n.mask, prdata[7:0] & n.mask);
      end
   end
   // =====
   // tests
   initial begin
      seed = 32'he9e09d52;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {debug_halt, ext_clk_pin, capture_pin} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `SC_ADDR, 0, 8'h00);
      apb(0, `CH_BASE, 0, 8'h00);
      apb(0, 8'h2C, 0, 8'h00);
      apb(1, 8'h01, 8'hFF);
      apb(1, `CH_BASE + `CH_VH_OFS, 8'h55);
      apb(1, `CH_BASE + `CH_VL_OFS, 8'h55);
      apb(0, `CH_BASE + `CH_VH_OFS, 0, 8'h00);
      apb(0, `CH_BASE + `CH_VL_OFS, 0, 8'h00);
      rel(1);
      $display("test regs done");
      apb(1, `MODL_ADDR, 8'h10);
      apb(1, `MODH_ADDR, 8'h00);
      apb(1, `SC_ADDR, 8'h48);
      rel(60);
      debug_halt <= 1'b1;
      rel(4);
      apb(1, `CNTL_ADDR, 8'hA5);
      apb(0, `CNTH_ADDR, 0, 8'h00);
      apb(0, `CNTL_ADDR, 0, 8'h00);
      apb(0, `CNTL_ADDR, 0, 8'h00);
      apb(1, `SC_ADDR, 8'h48);
      apb(0, `SC_ADDR, 0, 8'hC8);
      rel(2);
      cmp("irq", 8'h01, {7'h0, irq});
      apb(1, `SC_ADDR, 8'h48);
      apb(0, `SC_ADDR, 0, 8'h48);
      rel(3);
      cmp("irq", 8'h00, {7'h0, irq});
      debug_halt <= 1'b0;
      rel(60);
      apb(0, `SC_ADDR, 0, 8'h80, 8'h80);
      rel(40);
      apb(1, `SC_ADDR, 8'h48);
      apb(0, `SC_ADDR, 0, 8'h80, 8'h80);
      apb(1, `SC_ADDR, 8'h00);
      rel(1);
      $display("test overflow done");
      for (int k = 0; k < 4; k++) begin
         chs = 8'h40 | 8'(k << 2);
         apb(1, `CH_BASE, chs);
         rel(1);
         capture_pin[0] <= 1'b1;
         rel(6);
         apb(0, `CH_BASE, 0, {k[0], 7'h0}, 8'h80);
         apb(1, `CH_BASE, chs);
         rel(1);
         capture_pin[0] <= 1'b0;
         rel(6);
         cmp("irq", {7'h0, k[1]}, {7'h0, irq});
         apb(0, `CH_BASE, 0, {k[1], 7'h0}, 8'h80);
         apb(1, `CH_BASE, chs);
         rel(2);
      end
      $display("test capture done");
      apb(1, C1, 8'h10);
      apb(1, C1 + `CH_VH_OFS, 8'h00);
      apb(1, C1 + `CH_VL_OFS, 8'h05);
      apb(0, C1 + `CH_VH_OFS, 0, 8'h00);
      apb(0, C1 + `CH_VL_OFS, 0, 8'h05);
      apb(1, `SC_ADDR, 8'h08);
      rel(20);
      apb(0, C1, 0, 8'h90);
      apb(1, C1 + `CH_VH_OFS, 8'h00);
      apb(1, C1 + `CH_VL_OFS, 8'h07);
      rel(3);
      apb(0, C1 + `CH_VH_OFS, 0, 8'h00);
      apb(0, C1 + `CH_VL_OFS, 0, 8'h07);
      rel(2);
      $display("test compare done");
      apb(1, C1, 8'h28);
      apb(1, `CNTL_ADDR, 8'h00);
      rel(5);
      cmp("pwm_out", 8'h01, {7'h0, pwm_out[1]});
      rel(7);
      cmp("pwm_out", 8'h00, {7'h0, pwm_out[1]});
      apb(1, `CNTL_ADDR, 8'h00);
      apb(1, C1 + `CH_VH_OFS, 8'h00);
      apb(1, C1 + `CH_VL_OFS, 8'h0C);
      apb(0, C1 + `CH_VL_OFS, 0, 8'h07);
      rel(20);
      apb(0, C1 + `CH_VL_OFS, 0, 8'h0C);
      apb(1, `SC_ADDR, 8'h18);
      apb(1, `CNTL_ADDR, 8'h00);
      repeat (3) begin
         ext_clk_pin <= 1'b1;
         rel(3);
         ext_clk_pin <= 1'b0;
         rel(3);
      end
      apb(0, `CNTL_ADDR, 0, 8'h03);
      $display("test pwm done");
      apb(1, `SC_ADDR, 8'h20);
      apb(1, C1 + `CH_VH_OFS, 8'h00);
      apb(1, C1 + `CH_VL_OFS, 8'h10);
      apb(1, `SC_ADDR, 8'h28);
      rel(9);
      cmp("pwm_out", 8'h01, {7'h0, pwm_out[1]});
      rel(20);
      cmp("pwm_out", 8'h01, {7'h0, pwm_out[1]});
      $display("test center done");
      end_sim();
   end
   // the whole run is under five hundred cycles; twenty thousand means a hang
   initial begin
      #200000;
      miscompares++;
      end_sim();
   end
endmodule
bind timer_pwm timer_pwm_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq));

//--- testbench/timer_pwm_props.sv
// checker on the timer/pwm bus slave and interrupt ports
`timescale 1ns/1ps
module timer_pwm_props (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // interrupt
   input wire logic        irq
);
   // =====
   // properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_one;
      psel && !penable |=> pready;
   endproperty
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   property p_ready_cause;
      pready |-> $past(psel && !penable);
   endproperty
   property p_err_map;
      psel && !penable && (paddr > 8'h28 || paddr[1:0] != 2'h0) |=> pslverr;
   endproperty
   property p_ok_map;
      psel && !penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   property p_upper_zero;
      pready |-> prdata[31:8] == 24'h0;
   endproperty
   // flag and enable shown together in a read mean the request is already up
   property p_irq_flag;
      pready && !pwrite && paddr == 8'h00 && prdata[7:6] == 2'h3 |-> irq;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("no answer after setup");
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
   a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
   a_ok_map: assert property (p_ok_map) else $error("mapped access refused");
   a_err_zero: assert property (p_err_zero) else $error("refusal with data");
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
   a_irq_flag: assert property (p_irq_flag) else $error("flag and enable without irq");
   c_err: cover property (pslverr);
   c_irq: cover property (irq);
   c_flag_rd: cover property (pready && !pwrite && prdata[7]);
endmodule
